// >>> pmux_cfg.svh
// register map, field positions, reset values and selection codes of the output mux
`ifndef PMUX_CFG_SVH
`define PMUX_CFG_SVH

// register indices; byte address is four times the index
`define PMUX_IDX_IO_CFG 12'h170
`define PMUX_IDX_GPIO_SEL 12'h172
`define PMUX_IDX_STATUS 12'h174

// io_output_config fields
`define PMUX_CLK_SEL_MSB 12
`define PMUX_CLK_SEL_LSB 8
`define PMUX_CLK_DIS_BIT 6
`define PMUX_IMP_MSB 4
`define PMUX_IMP_LSB 0

// gpio_source_select fields
`define PMUX_G1_MSB 7
`define PMUX_G1_LSB 4
`define PMUX_G0_MSB 3
`define PMUX_G0_LSB 0

// reset values
`define PMUX_CLK_SEL_RST 5'h0c
`define PMUX_CLK_DIS_RST 1'b0
`define PMUX_GSEL_RST 4'h0

// clock source codes
`define PMUX_CLK_RX_BASE 5'h00
`define PMUX_CLK_RXDIV_BASE 5'h04
`define PMUX_CLK_TX_BASE 5'h08
`define PMUX_CLK_REF 5'h0c
`define PMUX_DIV_RATIO 3'h5
`define PMUX_DIV_HIGH 3'h2

// gpio source codes
`define PMUX_G_DEFAULT 4'h0
`define PMUX_G_TX_SFD 4'h1
`define PMUX_G_RX_SFD 4'h2
`define PMUX_G_WAKE 4'h3
`define PMUX_G_ENERGY 4'h4
`define PMUX_G_LED3 4'h6
`define PMUX_G_PRBS 4'h7
`define PMUX_G_LOW 4'h8
`define PMUX_G_HIGH 4'h9

// positions in the synchronised event vector
`define PMUX_EVT_RX_ER 0
`define PMUX_EVT_COL 1
`define PMUX_EVT_LED3 2
`define PMUX_EVT_PRBS 3
`define PMUX_EVT_ENERGY 4
`define PMUX_EVT_WAKE 5
`define PMUX_EVT_RX_SFD 6
`define PMUX_EVT_TX_SFD 7
`define PMUX_EVT_SPD_LSB 8
`define PMUX_EVT_SPD_MSB 9
`define PMUX_NEVT 10

// link speed codes
`define PMUX_SPEED_100 2'h1
`define PMUX_SPEED_1000 2'h2

`endif

// >>> pmux_pkg.sv
// types shared by the output mux modules
package pmux_pkg;

  typedef enum logic {
    PMUX_APB_IDLE,
    PMUX_APB_RESP
  } pmux_apb_t;

  typedef struct packed {
    logic [4:0] clk_sel;
    logic clk_dis;
    logic [4:0] imp;
    logic [3:0] g1_sel;
    logic [3:0] g0_sel;
    logic [4:0] clk_sel_act;
    logic clk_dis_act;
    logic [3:0] g1_act;
    logic [3:0] g0_act;
    logic ref_div;
    logic clk_out;
    logic gpio0;
    logic gpio1;
    logic [4:0] imp_out;
    pmux_apb_t apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmux_top_st_t;

endpackage : pmux_pkg

// >>> pmux_sig_if.sv
// synchronised source signals passed between the mux sub-blocks
`timescale 1ns/1ps
interface pmux_sig_if #(
  parameter int NCH = 4,
  parameter int NEVT = 10
);
  logic [NCH-1:0] rx_clk_s;
  logic [NCH-1:0] tx_clk_s;
  logic [NCH-1:0] rx_div;
  logic [NEVT-1:0] evt_s;

  modport sync_src (output rx_clk_s, output tx_clk_s, output evt_s);
  modport div_side (input rx_clk_s, output rx_div);
  modport core (input rx_clk_s, input tx_clk_s, input rx_div, input evt_s);
endinterface : pmux_sig_if

// >>> pmux_sync.sv
// two-flop synchronisers for every source coming from another domain
`timescale 1ns/1ps
module pmux_sync #(
  parameter int NCH = 4,
  parameter int NEVT = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] rx_raw,
  input wire logic [NCH-1:0] tx_raw,
  input wire logic [NEVT-1:0] evt_raw,
  pmux_sig_if.sync_src sig
);
  localparam int W = 2 * NCH + NEVT;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmux_sync_st_t;

  pmux_sync_st_t q;
  pmux_sync_st_t d;

  // first stage feeds only the second stage
  always_comb begin
    d = q;
    if (!rst_n) begin
      d.s1 = '0;
      d.s2 = '0;
    end else begin
      d.s1 = {evt_raw, tx_raw, rx_raw};
      d.s2 = q.s1; // R16
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign sig.rx_clk_s = q.s2[NCH-1:0];
  assign sig.tx_clk_s = q.s2[2*NCH-1:NCH];
  assign sig.evt_s = q.s2[W-1:2*NCH];
endmodule : pmux_sync

// >>> pmux_div5.sv
// divide-by-five of each synchronised receive clock, edge counted on ref_clk
`timescale 1ns/1ps
`include "pmux_cfg.svh"
module pmux_div5 #(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  pmux_sig_if.div_side sig
);
  typedef struct packed {
    logic [NCH-1:0][2:0] cnt;
    logic [NCH-1:0] prev;
    logic [NCH-1:0] out;
  } pmux_div_st_t;

  pmux_div_st_t q;
  pmux_div_st_t d;

  // duty is two fifths high; an odd ratio cannot be symmetric on edges alone
  always_comb begin
    d = q;
    if (!rst_n) begin
      d.cnt = '0;
      d.prev = '0;
      d.out = '0;
    end else begin
      d.prev = sig.rx_clk_s;
      for (int i = 0; i < NCH; i++) begin
        if (sig.rx_clk_s[i] && !q.prev[i]) begin
          if (q.cnt[i] == `PMUX_DIV_RATIO - 3'h1) begin // R3
            d.cnt[i] = 3'h0;
          end else begin
            d.cnt[i] = q.cnt[i] + 3'h1;
          end
          d.out[i] = (d.cnt[i] < `PMUX_DIV_HIGH);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign sig.rx_div = q.out;
endmodule : pmux_div5

// >>> pmux_top.sv
// clock output and gpio source mux with impedance trim, registers over apb
//
// Contract
// R1: the clock source field at bits 12:8 resets to 01100, which puts the reference clock on the pin.
// R2: codes 01000 to 01011 put the transmit clock of channel A, B, C or D on the clock pin.
// R3: codes 00100 to 00111 put the receive clock of channel A to D, divided by five, on the pin.
// R4: codes 00000 to 00011 put the undivided receive clock of channel A to D on the pin.
// R5: clock codes 01101 to 11111 are reserved and software does not program them.
// R6: bit 6 set stops the clock pin, and its reset value 0 lets the chosen clock through.
// R7: the five-bit impedance field at bits 4:0 sets MAC output impedance, 11111 lowest.
// R8: the impedance field loads the factory trim code at reset, not a fixed constant.
// R9: gpio selectors sit at bits 7:4 and 3:0, with 1001 constant high and 1000 constant low.
// R10: selector 0111 gives the test-pattern error or loss of sync, 0110 the third LED signal.
// R11: selector 0100 gives energy detect, valid only at 1000 or 100 megabit speed.
// R12: selector 0011 gives wake packet detect, 0010 the rx frame timestamp, 0001 the tx one.
// R13: pin one's selector resets to 0000, which drives the collision signal.
// R14: pin zero's selector resets to 0000, which drives the receive error signal.
// R15: gpio codes 0101 and 1010 to 1111 are reserved and software does not program them.
// R16: a selector change reaches its pin without a reset, after a stage into the pin domain.
`timescale 1ns/1ps
`include "pmux_cfg.svh"
module pmux_top #(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] rx_clk,
  input wire logic [NCH-1:0] tx_clk,
  input wire logic rx_er,
  input wire logic col,
  input wire logic third_led_indicator,
  input wire logic prbs_err,
  input wire logic energy_det,
  input wire logic wake_packet_detect,
  input wire logic rx_sfd,
  input wire logic tx_sfd,
  input wire logic [1:0] link_speed,
  input wire logic [4:0] trim_code,
  output logic clk_out,
  output logic gpio0,
  output logic gpio1,
  output logic [4:0] mac_imp
);

  pmux_sig_if #(.NCH(NCH), .NEVT(`PMUX_NEVT)) sig ();

  logic [`PMUX_NEVT-1:0] evt_raw;

  // gather the event pins in a fixed order for the synchroniser
  assign evt_raw[`PMUX_EVT_RX_ER] = rx_er;
  assign evt_raw[`PMUX_EVT_COL] = col;
  assign evt_raw[`PMUX_EVT_LED3] = third_led_indicator;
  assign evt_raw[`PMUX_EVT_PRBS] = prbs_err;
  assign evt_raw[`PMUX_EVT_ENERGY] = energy_det;
  assign evt_raw[`PMUX_EVT_WAKE] = wake_packet_detect;
  assign evt_raw[`PMUX_EVT_RX_SFD] = rx_sfd;
  assign evt_raw[`PMUX_EVT_TX_SFD] = tx_sfd;
  assign evt_raw[`PMUX_EVT_SPD_MSB:`PMUX_EVT_SPD_LSB] = link_speed;

  // every source crosses two flops before the mux looks at it
  pmux_sync #(.NCH(NCH), .NEVT(`PMUX_NEVT)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rx_raw(rx_clk),
    .tx_raw(tx_clk),
    .evt_raw(evt_raw),
    .sig(sig.sync_src)
  );

  // divided receive clocks for the divide-by-five codes
  pmux_div5 #(.NCH(NCH)) u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sig(sig.div_side)
  );

  // byte address of a register index
  function automatic logic [11:0] idx_addr(input logic [11:0] idx);
    idx_addr = {idx[9:0], 2'h0};
  endfunction : idx_addr

  // merge a 16-bit register with the two low byte lanes of a write
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    lane_merge = old;
    if (strb[0]) begin
      lane_merge[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      lane_merge[15:8] = wdata[15:8];
    end
  endfunction : lane_merge

  // energy detect only means something at 100 or 1000 megabit
  function automatic logic speed_ok(input logic [1:0] spd);
    speed_ok = (spd == `PMUX_SPEED_100) || (spd == `PMUX_SPEED_1000); // R11
  endfunction : speed_ok

  // gpio source codes, the same table for both pins
  //   0000 the pin's own signal: receive error on pin zero, collision on pin one
  //   0001 tx frame timestamp, 0010 rx frame timestamp, 0011 wake packet
  //   0100 energy detect, forced low at speeds other than 100 or 1000
  //   0110 third led signal, 0111 test-pattern error or loss of sync
  //   1000 constant low, 1001 constant high
  //   0101 and 1010 to 1111 reserved, pin held low so it never floats
  // an event pulse narrower than one ref_clk period may be missed
  // one gpio source; dflt is the pin's own code-0000 signal
  function automatic logic gpio_pick(
    input logic [3:0] code,
    input logic dflt,
    input logic [`PMUX_NEVT-1:0] ev
  );
    logic [1:0] spd;
    spd = ev[`PMUX_EVT_SPD_MSB:`PMUX_EVT_SPD_LSB];
    case (code)
      `PMUX_G_DEFAULT: gpio_pick = dflt; // R13 R14
      `PMUX_G_TX_SFD: gpio_pick = ev[`PMUX_EVT_TX_SFD]; // R12
      `PMUX_G_RX_SFD: gpio_pick = ev[`PMUX_EVT_RX_SFD]; // R12
      `PMUX_G_WAKE: gpio_pick = ev[`PMUX_EVT_WAKE]; // R12
      `PMUX_G_ENERGY: gpio_pick = ev[`PMUX_EVT_ENERGY] && speed_ok(spd); // R11
      `PMUX_G_LED3: gpio_pick = ev[`PMUX_EVT_LED3]; // R10
      `PMUX_G_PRBS: gpio_pick = ev[`PMUX_EVT_PRBS]; // R10
      `PMUX_G_LOW: gpio_pick = 1'b0; // R9
      `PMUX_G_HIGH: gpio_pick = 1'b1; // R9
      default: gpio_pick = 1'b0; // R15
    endcase
  endfunction : gpio_pick

  // clock source codes
  //   00000 to 00011 receive clock of channel a to d, undivided
  //   00100 to 00111 receive clock of channel a to d, divided by five
  //   01000 to 01011 transmit clock of channel a to d
  //   01100 reference clock, half of ref_clk
  //   01101 to 11111 reserved, pin held low
  // the two low code bits pick the channel in every group, so one
  // decode of bits 4:2 serves all three channel groups
  // clock pin source; reserved codes park the pin low
  function automatic logic clk_pick(
    input logic [4:0] code,
    input logic [NCH-1:0] rxs,
    input logic [NCH-1:0] rxd,
    input logic [NCH-1:0] txs,
    input logic refc
  );
    logic [1:0] ch;
    ch = code[1:0];
    clk_pick = 1'b0;
    if (code == `PMUX_CLK_REF) begin
      clk_pick = refc; // R1
    end else if (code[4:2] == `PMUX_CLK_TX_BASE >> 2) begin
      clk_pick = txs[ch]; // R2
    end else if (code[4:2] == `PMUX_CLK_RXDIV_BASE >> 2) begin
      clk_pick = rxd[ch]; // R3
    end else if (code[4:2] == `PMUX_CLK_RX_BASE >> 2) begin
      clk_pick = rxs[ch]; // R4
    end else begin
      clk_pick = 1'b0; // R5
    end
  endfunction : clk_pick

  // register map, one aligned 32-bit word each, data in bits 15:0
  // 0x5c0 io_output_config
  //   12:8 clock source code, resets to the reference clock code
  //   6 clock pin stop, resets to 0 so the clock runs
  //   4:0 mac impedance code, loads the trim input while in reset
  // 0x5c8 gpio_source_select
  //   7:4 pin one source, resets to collision
  //   3:0 pin zero source, resets to receive error
  // 0x5d0 status view, read only; writes are answered and dropped
  //   0 clock pin, 1 gpio0, 2 gpio1, 3 speed lets energy detect through
  //   8:4 clock source code now driving the pin
  // other bits read zero and ignore writes
  // any other address answers with pslverr and reads zero
  // only byte lanes 0 and 1 of a write count
  // a write with no strobe bit set changes nothing
  // register images as software sees them; reserved bits read zero
  function automatic logic [15:0] io_image(input pmux_pkg::pmux_top_st_t s);
    io_image = 16'h0000;
    io_image[`PMUX_CLK_SEL_MSB:`PMUX_CLK_SEL_LSB] = s.clk_sel;
    io_image[`PMUX_CLK_DIS_BIT] = s.clk_dis;
    io_image[`PMUX_IMP_MSB:`PMUX_IMP_LSB] = s.imp;
  endfunction : io_image

  function automatic logic [15:0] gpio_image(input pmux_pkg::pmux_top_st_t s);
    gpio_image = 16'h0000;
    gpio_image[`PMUX_G1_MSB:`PMUX_G1_LSB] = s.g1_sel;
    gpio_image[`PMUX_G0_MSB:`PMUX_G0_LSB] = s.g0_sel;
  endfunction : gpio_image

  // read-only view of what the pins are doing right now
  function automatic logic [15:0] status_image(
    input pmux_pkg::pmux_top_st_t s,
    input logic spd_valid
  );
    status_image = 16'h0000;
    status_image[0] = s.clk_out;
    status_image[1] = s.gpio0;
    status_image[2] = s.gpio1;
    status_image[3] = spd_valid;
    status_image[8:4] = s.clk_sel_act;
  endfunction : status_image

  pmux_pkg::pmux_top_st_t q;
  pmux_pkg::pmux_top_st_t d;

  logic hit_io;
  logic hit_gpio;
  logic hit_stat;
  logic access;
  logic [15:0] io_new;
  logic [15:0] gpio_new;

  // address decode, shared by read and write paths
  assign hit_io = (paddr == idx_addr(`PMUX_IDX_IO_CFG));
  assign hit_gpio = (paddr == idx_addr(`PMUX_IDX_GPIO_SEL));
  assign hit_stat = (paddr == idx_addr(`PMUX_IDX_STATUS));
  assign access = psel && penable;
  assign io_new = lane_merge(io_image(q), pwdata, pstrb);
  assign gpio_new = lane_merge(gpio_image(q), pwdata, pstrb);

  // bus timing, in ref_clk edges from the first access cycle
  //   edge 1: access seen while idle, answer and read data latched
  //   edge 2: pready stands for this cycle; a write lands here
  //   idle again after edge 2, so a new setup may follow at once
  // pin timing after a write lands
  //   next edge: staged copies of the selectors take the new code
  //   edge after that: the pin shows the new source
  // the staging stage keeps the pin mux off the bus decode path and
  // lets every selector change reach its pin on the same edge
  // source timing: two synchroniser edges plus the output flop,
  // and one more for the divided receive clocks
  // next state: apb slave with one wait state, staging of selectors, pin muxes
  always_comb begin
    d = q;
    if (!rst_n) begin
      d.clk_sel = `PMUX_CLK_SEL_RST; // R1
      d.clk_dis = `PMUX_CLK_DIS_RST; // R6
      d.imp = trim_code; // R8
      d.g1_sel = `PMUX_GSEL_RST; // R13
      d.g0_sel = `PMUX_GSEL_RST; // R14
      d.clk_sel_act = `PMUX_CLK_SEL_RST;
      d.clk_dis_act = `PMUX_CLK_DIS_RST;
      d.g1_act = `PMUX_GSEL_RST;
      d.g0_act = `PMUX_GSEL_RST;
      d.ref_div = 1'b0;
      d.clk_out = 1'b0;
      d.gpio0 = 1'b0;
      d.gpio1 = 1'b0;
      d.imp_out = trim_code; // R8
      d.apb = pmux_pkg::PMUX_APB_IDLE;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
    end else begin
      // reference clock at half of ref_clk, locked to the crystal input
      d.ref_div = !q.ref_div;

      case (q.apb)
        pmux_pkg::PMUX_APB_IDLE: begin
          d.pready = 1'b0;
          if (access) begin
            // answer prepared now, presented on the next cycle
            d.apb = pmux_pkg::PMUX_APB_RESP;
            d.pready = 1'b1;
            d.pslverr = !(hit_io || hit_gpio || hit_stat);
            if (hit_io) begin
              d.prdata = {16'h0000, io_image(q)};
            end else if (hit_gpio) begin
              d.prdata = {16'h0000, gpio_image(q)};
            end else if (hit_stat) begin
              d.prdata = {16'h0000, status_image(q, speed_ok(
                sig.evt_s[`PMUX_EVT_SPD_MSB:`PMUX_EVT_SPD_LSB]))};
            end else begin
              d.prdata = 32'h0000_0000;
            end
          end
        end
        pmux_pkg::PMUX_APB_RESP: begin
          // the write lands at the edge that sees pready high
          d.apb = pmux_pkg::PMUX_APB_IDLE;
          d.pready = 1'b0;
          d.pslverr = 1'b0;
          d.prdata = 32'h0000_0000;
          if (access && pwrite && hit_io) begin
            d.clk_sel = io_new[`PMUX_CLK_SEL_MSB:`PMUX_CLK_SEL_LSB];
            d.clk_dis = io_new[`PMUX_CLK_DIS_BIT]; // R6
            d.imp = io_new[`PMUX_IMP_MSB:`PMUX_IMP_LSB]; // R7
          end
          if (access && pwrite && hit_gpio) begin
            d.g1_sel = gpio_new[`PMUX_G1_MSB:`PMUX_G1_LSB]; // R9
            d.g0_sel = gpio_new[`PMUX_G0_MSB:`PMUX_G0_LSB]; // R9
          end
        end
        default: begin
          d.apb = pmux_pkg::PMUX_APB_IDLE;
          d.pready = 1'b0;
        end
      endcase

      // selections move into the pin stage one cycle after the write
      d.clk_sel_act = q.clk_sel; // R16
      d.clk_dis_act = q.clk_dis; // R16
      d.g1_act = q.g1_sel; // R16
      d.g0_act = q.g0_sel; // R16
      d.imp_out = q.imp; // R7

      // disable parks the pin low rather than floating it
      if (q.clk_dis_act) begin
        d.clk_out = 1'b0; // R6
      end else begin
        d.clk_out = clk_pick(q.clk_sel_act, sig.rx_clk_s, sig.rx_div,
                             sig.tx_clk_s, q.ref_div);
      end

      d.gpio0 = gpio_pick(q.g0_act, sig.evt_s[`PMUX_EVT_RX_ER], sig.evt_s); // R14
      d.gpio1 = gpio_pick(q.g1_act, sig.evt_s[`PMUX_EVT_COL], sig.evt_s); // R13
    end
  end

  // single state register of the block
  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  // outputs come straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign clk_out = q.clk_out;
  assign gpio0 = q.gpio0;
  assign gpio1 = q.gpio1;
  assign mac_imp = q.imp_out;

  // limitation: clock sources are sampled on ref_clk, so they must run
  // well below half of ref_clk to reach the pin with their shape intact

endmodule : pmux_top

// >>> pmux_top_asserts.sv
// concurrent checks on the ports of the clock and gpio output mux
`timescale 1ns/1ps
module pmux_top_asserts #(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [NCH-1:0] rx_clk,
  input wire logic [NCH-1:0] tx_clk,
  input wire logic rx_er,
  input wire logic col,
  input wire logic [4:0] trim_code,
  input wire logic clk_out,
  input wire logic gpio0,
  input wire logic gpio1,
  input wire logic [4:0] mac_imp
);
  logic [15:0] cfg_q;
  logic [7:0] gsel_q;
  logic [2:0] age_c_q;
  logic [2:0] age_g_q;
  logic rst_seen_q;
  logic wr_c;
  logic wr_g;
  // a write lands at the edge where the access phase sees pready
  assign wr_c = psel && penable && pready && pwrite && paddr == 12'h5c0;
  assign wr_g = psel && penable && pready && pwrite && paddr == 12'h5c8;
  // shadow selectors; the age counters keep checks off the staging window
  always_ff @(posedge ref_clk) begin
    rst_seen_q <= !rst_n;
    if (!rst_n) begin
      cfg_q <= {8'h0c, 3'h0, trim_code};
      gsel_q <= 8'h00;
      age_c_q <= 3'h0;
      age_g_q <= 3'h0;
    end else begin
      cfg_q <= wr_c ? (pwdata[15:0] & 16'h1f5f) : cfg_q;
      gsel_q <= wr_g ? pwdata[7:0] : gsel_q;
      age_c_q <= wr_c ? 3'h0 : (age_c_q == 3'h7 ? age_c_q : age_c_q + 3'h1);
      age_g_q <= wr_g ? 3'h0 : (age_g_q == 3'h7 ? age_g_q : age_g_q + 3'h1);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_g0_const_high: assert property (age_g_q > 3'h4 && gsel_q[3:0] == 4'h9 |-> gpio0)
    else $error("gpio0 not high under constant one");
  chk_g1_const_low: assert property (age_g_q > 3'h4 && gsel_q[7:4] == 4'h8 |-> !gpio1)
    else $error("gpio1 not low under constant zero");
  chk_g0_rx_err: assert property (age_g_q > 3'h4 && gsel_q[3:0] == 4'h0
    |-> gpio0 == $past(rx_er, 3)) else $error("gpio0 does not follow rx error");
  chk_g1_collision: assert property (age_g_q > 3'h4 && gsel_q[7:4] == 4'h0
    |-> gpio1 == $past(col, 3)) else $error("gpio1 does not follow collision");
  chk_clk_stopped: assert property (age_c_q > 3'h4 && cfg_q[6] |-> !clk_out)
    else $error("clock pin runs while disabled");
  chk_ref_toggle: assert property (age_c_q > 3'h4 && cfg_q[12:6] == 7'h30
    |-> clk_out != $past(clk_out)) else $error("reference clock not toggling");
  chk_tx_route: assert property (age_c_q > 3'h4 && cfg_q[12:10] == 3'h2 && !cfg_q[6]
    |-> clk_out == $past(tx_clk[cfg_q[9:8]], 3)) else $error("wrong transmit clock");
  chk_rx_route: assert property (age_c_q > 3'h4 && cfg_q[12:10] == 3'h0 && !cfg_q[6]
    |-> clk_out == $past(rx_clk[cfg_q[9:8]], 3)) else $error("wrong receive clock");
  chk_imp_follow: assert property (age_c_q > 3'h2 |-> mac_imp == cfg_q[4:0])
    else $error("impedance output differs from field");
  chk_trim_load: assert property (disable iff (1'b0) rst_seen_q |-> mac_imp == $past(trim_code))
    else $error("impedance not loaded from trim in reset");
endmodule : pmux_top_asserts

bind pmux_top pmux_top_asserts #(.NCH(NCH)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .rx_clk(rx_clk), .tx_clk(tx_clk), .rx_er(rx_er), .col(col),
  .trim_code(trim_code), .clk_out(clk_out), .gpio0(gpio0), .gpio1(gpio1), .mac_imp(mac_imp));

// >>> pmux_board.sv
// board side: channel clock sources and a rise counter on the clock pin
`timescale 1ns/1ps
module pmux_board (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic clk_out,
  output logic [3:0] rx_clk,
  output logic [3:0] tx_clk,
  output logic [15:0] rises
);
  int div_q [8];
  logic last_q;
  initial begin
    rx_clk = 4'h0;
    tx_clk = 4'h0;
    rises = 16'h0;
    last_q = 1'b0;
    foreach (div_q[i]) div_q[i] = 0;
  end
  // channel clocks are whole multiples of ref_clk so edge counts are predictable
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      div_q[i] = (div_q[i] + 1) % (i + 3);
      div_q[i + 4] = (div_q[i + 4] + 1) % (i + 2);
      if (div_q[i] == 0) rx_clk[i] <= ~rx_clk[i];
      if (div_q[i + 4] == 0) tx_clk[i] <= ~tx_clk[i];
    end
    last_q <= clk_out;
    rises <= clr ? 16'h0 : rises + 16'(clk_out && !last_q);
  end
endmodule : pmux_board

// >>> pmux_tb.sv
// self-checking bench for the clock and gpio output mux
`timescale 1ns/1ps
`include "pmux_cfg.svh"
module tb;
  localparam logic [11:0] A_C = 12'(`PMUX_IDX_IO_CFG * 4);
  localparam logic [11:0] A_G = 12'(`PMUX_IDX_GPIO_SEL * 4);
  localparam logic [4:0] TRIM = 5'h0b;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, clk_out, gpio0, gpio1, clr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] rx_clk, tx_clk;
  logic [7:0] ev;
  logic [1:0] link_speed;
  logic [4:0] mac_imp;
  logic [15:0] rises;
  int num_errors, total_checks, cycles;
  pmux_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_clk(rx_clk), .tx_clk(tx_clk), .rx_er(ev[0]),
    .col(ev[1]), .third_led_indicator(ev[2]), .prbs_err(ev[3]), .energy_det(ev[4]),
    .wake_packet_detect(ev[5]), .rx_sfd(ev[6]), .tx_sfd(ev[7]), .link_speed(link_speed),
    .trim_code(TRIM), .clk_out(clk_out), .gpio0(gpio0), .gpio1(gpio1), .mac_imp(mac_imp));
  pmux_board board_u (.ref_clk(ref_clk), .clr(clr), .clk_out(clk_out), .rx_clk(rx_clk),
    .tx_clk(tx_clk), .rises(rises));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one apb transfer; holds the request until pready, then one idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk({31'h0, pready}, 32'h1, "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic t_regs();
    ev <= 8'h01;
    apb(1'b0, A_C, 16'h0);
    chk(rd, {19'h0, 5'h0c, 3'h0, TRIM}, "clock config reset");
    chk({27'h0, mac_imp}, {27'h0, TRIM}, "impedance trim");
    apb(1'b0, A_G, 16'h0);
    chk(rd, 32'h0, "gpio select reset");
    chk({30'h0, gpio1, gpio0}, 32'h1, "rx error on gpio0");
    ev <= 8'h02;
    repeat (5) @(posedge ref_clk);
    chk({30'h0, gpio1, gpio0}, 32'h2, "collision on gpio1");
    apb(1'b1, A_C, 16'hffff);
    apb(1'b0, A_C, 16'h0);
    chk(rd, 32'h1f5f, "clock config fields");
    chk({27'h0, mac_imp}, 32'h1f, "lowest impedance");
    apb(1'b1, A_C, 16'h0c00);
    repeat (2) @(posedge ref_clk);
    chk({27'h0, mac_imp}, 32'h0, "highest impedance");
    apb(1'b1, A_G, 16'hffff);
    apb(1'b0, A_G, 16'h0);
    chk(rd, 32'hff, "gpio select fields");
    chk({30'h0, gpio1, gpio0}, 32'h0, "reserved gpio code held low");
    apb(1'b0, 12'h5e0, 16'h0);
    chk({31'h0, er}, 32'h1, "unmapped address refused");
    apb(1'b0, 12'(`PMUX_IDX_STATUS * 4), 16'h0);
    chk(rd & 32'hffff_fffe, 32'h0000_00c0, "status view");
    chk({31'h0, er}, 32'h0, "status answered without error");
    $display("test regs done");
  endtask : t_regs
  // each code sees only its own source high, then only its own source low
  task automatic t_gpio();
    logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
    int idx [8] = '{7, 6, 5, 4, 2, 3, 0, 0};
    logic e;
    link_speed <= 2'h1;
    foreach (codes[i]) begin
      apb(1'b1, A_G, {8'h0, codes[i], codes[i]});
      for (int v = 0; v < 2; v++) begin
        ev <= v ? ~(8'h1 << idx[i]) : (8'h1 << idx[i]);
        repeat (5) @(posedge ref_clk);
        e = (codes[i] == 4'h9) || (codes[i] != 4'h8 && v == 0);
        chk({30'h0, gpio1, gpio0}, {30'h0, e, e}, "gpio source");
      end
    end
    apb(1'b1, A_G, 16'h0044);
    ev <= 8'h10;
    link_speed <= 2'h0;
    repeat (5) @(posedge ref_clk);
    chk({30'h0, gpio1, gpio0}, 32'h0, "energy gated by speed");
    $display("test gpio done");
  endtask : t_gpio
  task automatic t_clk();
    int exp [14] = '{100, 75, 60, 50, 20, 15, 12, 10, 150, 100, 75, 60, 300, 0};
    int n;
    for (int k = 0; k < 14; k++) begin
      apb(1'b1, A_C, k < 13 ? {3'h0, 5'(k), 3'h0, TRIM} : {8'h0c, 3'h2, TRIM});
      repeat (8) @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (600) @(posedge ref_clk);
      n = int'(rises);
      chk({31'h0, n <= exp[k] + 1 && n + 1 >= exp[k]}, 32'h1, "clock rate");
    end
    $display("test clk done");
  endtask : t_clk
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard well above the longest run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 8'h00;
    link_speed = 2'h0;
    clr = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_gpio();
    t_clk();
    results();
  end
endmodule : tb
